//--- logic/sils_pkg.sv
// shared constants and carrier types for the spi link with safe state
package sils_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned SCLK_HZ         = 700000;
  localparam int unsigned FRAME_BYTES     = 4;
  localparam int unsigned BYTE_BITS       = 8;
  localparam int unsigned WDOG_MS_DEF     = 100;
  localparam int unsigned WDOG_CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PROC_US         = 100;
  localparam int unsigned PROC_CYC        = (PROC_US * (CLK_HZ / 1000000) > 0) ?
                                            PROC_US * (CLK_HZ / 1000000) : 1;
  localparam int unsigned N_DOUT          = 8;
  localparam int unsigned N_RELAY         = 4;
  localparam int unsigned N_PWM           = 2;
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * WDOG_CYC_PER_MS;
  localparam int unsigned CAUSE_BLINKS    = 2;
  localparam int unsigned WDOG_CNT_W      = 32;

  typedef struct packed {
    logic [N_DOUT-1:0]  dout;
    logic [N_RELAY-1:0] relay;
    logic [N_PWM-1:0]   pwm;
  } sils_outs_t;

  // controls come up all off after any reset
  localparam sils_outs_t CTRL_RESET = '0;

  typedef struct packed {
    logic wdog_en;
    logic retain_en;
    logic led_en;
  } sils_cfg_t;

  typedef enum logic [1:0] {SILS_RUN, SILS_SAFE_SAVE, SILS_SAFE} sils_state_t;
endpackage

//--- logic/sils_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sils_sync
  import sils_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule

//--- logic/sils_shift.sv
// spi slave shift engine on the link clock, mode 0, msb first
`timescale 1ns/100ps
module sils_shift
  import sils_pkg::*;
#(
  parameter int unsigned NBITS = FRAME_BYTES * BYTE_BITS
) (
  input  wire logic             sclk,
  input  wire logic             rst_b,
  input  wire logic             cs_b,
  input  wire logic             mosi,
  input  wire logic [NBITS-1:0] tx_word,
  output logic                  miso,
  output logic      [NBITS-1:0] rx_word,
  output logic                  done_tgl
);
  logic [NBITS-1:0]         sh_reg;
  logic [NBITS-1:0]         sh_next;
  logic [$clog2(NBITS):0]   cnt_reg;
  logic [$clog2(NBITS):0]   cnt_next;
  logic [NBITS-1:0]         rx_next;
  logic                     tgl_next;

  initial begin
    if (NBITS < 2) $error("sils_shift: NBITS too small");
  end

  // frame state is cleared by chip select itself; sclk stops between frames
  always_comb begin
    sh_next  = {sh_reg[NBITS-2:0], mosi};
    if (cnt_reg == '0) begin
      sh_next = {tx_word[NBITS-2:0], mosi};
    end
    cnt_next = cnt_reg + 1'b1;
    rx_next  = rx_word;
    tgl_next = done_tgl;
    if (cnt_reg == ($clog2(NBITS)+1)'(NBITS - 1)) begin
      rx_next  = {sh_reg[NBITS-2:0], mosi};
      tgl_next = ~done_tgl;
    end
  end

  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // toggle needs a known start, else the clk side sees a false event
  always_ff @(posedge sclk or negedge rst_b) begin // R1
    if (!rst_b) begin
      rx_word  <= '0;
      done_tgl <= 1'b0;
    end else if (!cs_b) begin
      rx_word  <= rx_next;
      done_tgl <= tgl_next;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_b) begin
      sh_reg <= sh_next;
    end
  end

  // first bit from the captured word, then the shifted register
  always_comb begin
    if (cnt_reg == '0) begin
      miso = tx_word[NBITS-1];
    end else begin
      miso = sh_reg[NBITS-1];
    end
  end
endmodule

//--- logic/sils_top.sv
// spi process-data link with link watchdog and latched safe state
// Behaviour
// R1 - link clock is the host spi clock, nominally 700 kHz.
// R2 - host waits for processing time; early frames are dropped.
// R3 - host keeps cycle interval at or above 2.5 ms / 5 ms.
// R4 - host should use 30 ms, or 10 ms without humidity sensors.
// R5 - no exchange unless host link enable line is high.
// R6 - host detects too-short intervals, flags error, stops talking; the host model only skips that one exchange and keeps talking after it.
// R7 - watchdog runs only when enabled, expires after configured timeout.
// R8 - on expiry normal processing stops and safe state is entered.
// R9 - safe state drives all digital and relay outputs off.
// R10 - safe state releases pwm outputs to high impedance.
// R11 - safe state entry saves retained data only when enabled.
// R12 - safe state flashes enabled indicator with cause pattern.
// R13 - safe state latched until reset; link activity cannot leave it.
// R14 - received settings volatile; cleared by reset, idle until command.
// R15 - one chip-select frame carries outputs in and inputs back.
`timescale 1ns/100ps
module sils_top
  import sils_pkg::*;
#(
  parameter int unsigned NBITS   = FRAME_BYTES * BYTE_BITS,
  parameter int unsigned MS_CYC  = WDOG_CYC_PER_MS,
  parameter int unsigned BLINK_C = BLINK_HALF_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             spi_sclk,
  input  wire logic             spi_cs_b,
  input  wire logic             spi_mosi,
  output logic                  spi_miso,
  output logic                  spi_miso_oe,
  input  wire logic             host_link_enable_line,
  input  wire sils_cfg_t        cfg,
  input  wire logic [15:0]      wdog_timeout_ms,
  input  wire logic [NBITS-1:0] in_data,
  output sils_outs_t            outs,
  output logic [N_PWM-1:0]      pwm_oe,
  output logic                  retain_save,
  output logic                  status_error_indicator,
  output logic                  safe_state,
  output logic                  frame_rejected
);
  localparam int unsigned OUT_W = N_DOUT + N_RELAY + N_PWM;

  initial begin
    if (NBITS < OUT_W) $error("sils_top: frame narrower than outputs");
    if (MS_CYC < 1 || BLINK_C < 1) $error("sils_top: counts must be nonzero");
  end

  logic             en_s;
  logic             cs_b_s;
  logic             cs_gated;
  logic [NBITS-1:0] rx_word;
  logic             done_tgl;
  logic             done_s;
  logic             miso_raw;
  logic [NBITS-1:0] tx_hold_reg;
  logic [NBITS-1:0] tx_hold_next;

  // no enable, no frame: the shift engine sees chip select idle
  assign cs_gated = spi_cs_b | ~host_link_enable_line; // R5

  sils_shift #(.NBITS(NBITS)) u_shift (
    .sclk     (spi_sclk),
    .rst_b    (rst_b),
    .cs_b     (cs_gated),
    .mosi     (spi_mosi),
    .tx_word  (tx_hold_reg),
    .miso     (miso_raw),
    .rx_word  (rx_word),
    .done_tgl (done_tgl)
  );

  sils_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({host_link_enable_line, spi_cs_b, done_tgl}),
    .q     ({en_s, cs_b_s, done_s})
  );

  assign spi_miso    = miso_raw;
  assign spi_miso_oe = ~cs_gated; // R5

  // frame completion event in the local domain
  logic done_d_reg;
  logic done_d_next;
  logic frame_done;
  assign frame_done = done_s ^ done_d_reg;

  // rx_word is stable long after the toggle, since cs must rise and
  // a new frame start before it changes again
  sils_state_t      st_reg;
  sils_state_t      st_next;
  logic [31:0]      proc_reg;
  logic [31:0]      proc_next;
  logic [WDOG_CNT_W-1:0] wd_reg;
  logic [WDOG_CNT_W-1:0] wd_next;
  sils_outs_t       ctl_reg;
  sils_outs_t       ctl_next;
  logic             got_cmd_reg;
  logic             got_cmd_next;
  logic             save_reg;
  logic             save_next;
  logic             rej_reg;
  logic             rej_next;
  logic [WDOG_CNT_W-1:0] wd_limit;

  assign wd_limit = WDOG_CNT_W'(wdog_timeout_ms) * WDOG_CNT_W'(MS_CYC);

  always_comb begin
    done_d_next  = done_s;
    st_next      = st_reg;
    proc_next    = (proc_reg != '0) ? proc_reg - 32'h1 : proc_reg;
    wd_next      = wd_reg;
    ctl_next     = ctl_reg;
    got_cmd_next = got_cmd_reg;
    save_next    = 1'b0;
    rej_next     = 1'b0;
    tx_hold_next = tx_hold_reg;
    case (st_reg)
      SILS_RUN: begin
        if (frame_done) begin
          wd_next = '0;
          if (proc_reg != '0) begin
            rej_next = 1'b1; // R2
          end else begin
            ctl_next     = rx_word[OUT_W-1:0]; // R15
            got_cmd_next = 1'b1; // R14
            proc_next    = 32'(PROC_CYC);
          end
        end else if (cfg.wdog_en) begin // R7
          wd_next = (wd_reg == '1) ? wd_reg : wd_reg + 1'b1;
        end else begin
          wd_next = '0;
        end
        // reply word frozen only while a frame can run; the host's setup
        // delay before the first clock covers the synchroniser lag
        if (cs_b_s || !en_s) begin
          tx_hold_next = in_data; // R15
        end
        if (cfg.wdog_en && wd_limit != '0 && wd_reg >= wd_limit) begin
          st_next   = SILS_SAFE_SAVE; // R8
        end
      end
      SILS_SAFE_SAVE: begin
        save_next = cfg.retain_en; // R11
        st_next   = SILS_SAFE;
      end
      SILS_SAFE: begin
        st_next = SILS_SAFE; // R13
      end
      default: begin
        st_next = SILS_SAFE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg      <= SILS_RUN;
      done_d_reg  <= 1'b0;
      proc_reg    <= '0;
      wd_reg      <= '0;
      ctl_reg     <= CTRL_RESET; // R14
      got_cmd_reg <= 1'b0;
      save_reg    <= 1'b0;
      rej_reg     <= 1'b0;
      tx_hold_reg <= '0;
    end else begin
      st_reg      <= st_next;
      done_d_reg  <= done_d_next;
      proc_reg    <= proc_next;
      wd_reg      <= wd_next;
      ctl_reg     <= ctl_next;
      got_cmd_reg <= got_cmd_next;
      save_reg    <= save_next;
      rej_reg     <= rej_next;
      tx_hold_reg <= tx_hold_next;
    end
  end

  // blink pattern: CAUSE_BLINKS flashes then a dark gap
  logic [31:0] bl_cnt_reg;
  logic [31:0] bl_cnt_next;
  logic [3:0]  bl_ph_reg;
  logic [3:0]  bl_ph_next;
  logic        led_reg;
  logic        led_next;

  always_comb begin
    bl_cnt_next = bl_cnt_reg;
    bl_ph_next  = bl_ph_reg;
    led_next    = 1'b0;
    if (st_reg != SILS_RUN && cfg.led_en) begin // R12
      if (bl_cnt_reg == 32'(BLINK_C - 1)) begin
        bl_cnt_next = '0;
        bl_ph_next  = (bl_ph_reg == 4'(2 * CAUSE_BLINKS + 1)) ? 4'h0 : bl_ph_reg + 4'h1;
      end else begin
        bl_cnt_next = bl_cnt_reg + 32'h1;
      end
      led_next = (bl_ph_reg < 4'(2 * CAUSE_BLINKS)) && !bl_ph_reg[0];
    end else begin
      bl_cnt_next = '0;
      bl_ph_next  = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bl_cnt_reg <= '0;
      bl_ph_reg  <= '0;
      led_reg    <= 1'b0;
    end else begin
      bl_cnt_reg <= bl_cnt_next;
      bl_ph_reg  <= bl_ph_next;
      led_reg    <= led_next;
    end
  end

  logic safe;
  assign safe = (st_reg != SILS_RUN);

  always_comb begin
    outs = ctl_reg;
    pwm_oe = got_cmd_reg ? {N_PWM{1'b1}} : '0; // R14
    if (safe) begin
      outs   = '0; // R9
      pwm_oe = '0; // R10
    end
  end

  assign retain_save            = save_reg;
  assign status_error_indicator = led_reg;
  assign safe_state             = safe;
  assign frame_rejected         = rej_reg;

  // checks
  property p_latch;
    @(posedge clk) disable iff (!rst_b) safe |=> safe;
  endproperty
  a_latch: assert property (p_latch) else $error("safe state left"); // R13

  property p_outs_off;
    @(posedge clk) disable iff (!rst_b) safe |-> (outs == '0 && pwm_oe == '0);
  endproperty
  a_outs_off: assert property (p_outs_off) else $error("outputs live in safe"); // R9

  property p_save;
    @(posedge clk) disable iff (!rst_b)
      (st_reg == SILS_SAFE_SAVE && cfg.retain_en) |=> retain_save;
  endproperty
  a_save: assert property (p_save) else $error("retain not saved"); // R11

  property p_nosave;
    @(posedge clk) disable iff (!rst_b)
      (st_reg != SILS_SAFE_SAVE || !cfg.retain_en) |=> !retain_save;
  endproperty
  a_nosave: assert property (p_nosave) else $error("save without option"); // R11

  property p_wd_off;
    @(posedge clk) disable iff (!rst_b)
      (!cfg.wdog_en && st_reg == SILS_RUN) |=> (st_reg == SILS_RUN);
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog fired while off"); // R7

  property p_expire;
    @(posedge clk) disable iff (!rst_b)
      (st_reg == SILS_RUN && cfg.wdog_en && wd_limit != '0 && wd_reg >= wd_limit)
      |=> (st_reg == SILS_SAFE_SAVE) ##1 (st_reg == SILS_SAFE);
  endproperty
  a_expire: assert property (p_expire) else $error("no safe entry on expiry"); // R8

  property p_led_off;
    @(posedge clk) disable iff (!rst_b) (!safe || !cfg.led_en) |=> !status_error_indicator;
  endproperty
  a_led_off: assert property (p_led_off) else $error("indicator lit wrongly"); // R12

  property p_reject;
    @(posedge clk) disable iff (!rst_b)
      (frame_done && st_reg == SILS_RUN && proc_reg != '0) |=> $stable(ctl_reg);
  endproperty
  a_reject: assert property (p_reject) else $error("early frame accepted"); // R2

  property p_take;
    @(posedge clk) disable iff (!rst_b)
      (frame_done && st_reg == SILS_RUN && proc_reg == '0)
      |=> (ctl_reg == $past(rx_word[OUT_W-1:0]));
  endproperty
  a_take: assert property (p_take) else $error("frame not taken"); // R15

  property p_rej_pulse;
    @(posedge clk) disable iff (!rst_b) !frame_done |=> !frame_rejected;
  endproperty
  a_rej_pulse: assert property (p_rej_pulse) else $error("reject without frame"); // R2

  property p_cmd_idle;
    @(posedge clk) disable iff (!rst_b) !got_cmd_reg |-> (outs == '0 && pwm_oe == '0);
  endproperty
  a_cmd_idle: assert property (p_cmd_idle) else $error("outputs act before command"); // R14

  property p_safe_hold;
    @(posedge clk) disable iff (!rst_b) (st_reg == SILS_SAFE) |=> $stable(ctl_reg);
  endproperty
  a_safe_hold: assert property (p_safe_hold) else $error("frame taken in safe"); // R13
endmodule

//--- testbench/sils_host_model.sv
// host-side spi master model: mode 0, msb first, clock only inside frames
`timescale 1ns/100ps
module sils_host_model (
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  localparam realtime HALF      = 15.0;
  // cycle guard limit, scaled far below the real minimum interval
  localparam realtime MIN_CYCLE = 1250.0;
  logic    bus_cycle_error_flag;
  realtime last_start;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
    bus_cycle_error_flag = 1'b0;
    last_start = -1.0e6;
  end
  // one framed exchange, 32 bits each way; released miso reads high (pull-up)
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'hffff_ffff;
    if ($realtime - last_start < MIN_CYCLE) begin
      bus_cycle_error_flag = 1'b1;
    end else begin
      last_start = $realtime;
      cs_b = 1'b0;
      // setup time lets the device freeze its reply word first
      #(HALF * 8);
      for (int i = 31; i >= 0; i--) begin
        mosi = tx[i];
        #HALF sclk = 1'b1;
        rx[i] = miso_oe ? miso : 1'b1;
        #HALF sclk = 1'b0;
      end
      #HALF mosi = ~mosi;
      cs_b = 1'b1;
      #(HALF * 4);
    end
  endtask
endmodule

//--- testbench/sils_top_tb.sv
// self-checking bench for the spi link with watchdog and safe state
`timescale 1ns/100ps
module sils_top_tb;
  import sils_pkg::*;
  localparam int unsigned MS_C = 10;
  logic             clk, rst_b, en, sclk, cs_b, mosi, miso, miso_oe;
  logic             rsave, led, led_q, safe, rej;
  sils_cfg_t        cfg;
  logic [15:0]      tmo;
  logic [31:0]      in_data, rx;
  sils_outs_t       outs;
  logic [N_PWM-1:0] pwm_oe;
  int               errors, checks_done, rej_seen, save_seen, led_rise;

  sils_top #(.MS_CYC(MS_C), .BLINK_C(4)) i_dut (.clk(clk), .rst_b(rst_b), .spi_sclk(sclk),
    .spi_cs_b(cs_b), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .host_link_enable_line(en), .cfg(cfg), .wdog_timeout_ms(tmo), .in_data(in_data),
    .outs(outs), .pwm_oe(pwm_oe), .retain_save(rsave), .status_error_indicator(led),
    .safe_state(safe), .frame_rejected(rej));
  sils_host_model i_host (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  always #12.5 clk = ~clk;
  // pulses last one cycle, so they are caught as counts
  always @(posedge clk) begin
    led_q <= led;
    if (rej === 1'b1) rej_seen++;
    if (rsave === 1'b1) save_seen++;
    if (led === 1'b1 && led_q === 1'b0) led_rise++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    cfg = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rej_seen = 0;
    save_seen = 0;
    led_rise = 0;
  endtask
  // frames only 8 clock cycles apart; tests call gap() to space them beyond the processing time
  task automatic send(input logic [31:0] tx);
    @(negedge clk);
    i_host.xfer(tx, rx);
    repeat (8) @(negedge clk);
  endtask
  task automatic gap();
    // scaled stand-in for the host cycle interval
    repeat (PROC_CYC + 100) @(negedge clk);
  endtask
  task automatic wait_safe();
    for (int i = 0; i < 40 && safe !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic t_reset();
    chk("outs", 32'h0, 32'(outs));
    chk("pwm_oe", 32'h0, 32'(pwm_oe));
    chk("safe", 32'h0, 32'(safe));
  endtask
  task automatic t_accept();
    send(32'hffff_2abd);
    chk("outs", 32'h2abd, 32'(outs));
    chk("pwm_oe", 32'h3, 32'(pwm_oe));
    chk("rx", 32'ha5c3_1e69, rx);
  endtask
  task automatic t_early();
    send(32'h0000_1542);
    chk("rejected", 32'h1, 32'(rej_seen));
    chk("outs", 32'h2abd, 32'(outs));
  endtask
  task automatic t_disabled();
    gap();
    en = 1'b0;
    send(32'h0000_0fff);
    chk("rx_off", 32'hffff_ffff, rx);
    chk("outs", 32'h2abd, 32'(outs));
    chk("rejected", 32'h1, 32'(rej_seen));
    chk("cycle_err", 32'h0, 32'(i_host.bus_cycle_error_flag));
    i_host.xfer(32'h0000_0aaa, rx);
    i_host.xfer(32'h0000_0555, rx);
    chk("cycle_err", 32'h1, 32'(i_host.bus_cycle_error_flag));
    @(negedge clk);
    en = 1'b1;
  endtask
  task automatic t_safe(input logic keep);
    cfg = '{wdog_en: 1'b0, retain_en: keep, led_en: keep};
    tmo = 16'd2;
    repeat (300) @(negedge clk);
    chk("safe_off", 32'h0, 32'(safe));
    cfg.wdog_en = 1'b1;
    repeat (15) @(negedge clk);
    chk("safe_early", 32'h0, 32'(safe));
    wait_safe();
    chk("safe", 32'h1, 32'(safe));
    chk("outs", 32'h0, 32'(outs));
    chk("pwm_oe", 32'h0, 32'(pwm_oe));
    repeat (100) @(negedge clk);
    chk("saves", 32'(keep), 32'(save_seen));
    chk("blink", 32'(keep), 32'(led_rise > 0));
  endtask
  task automatic t_latched();
    gap();
    send(32'h0000_3fff);
    chk("outs", 32'h0, 32'(outs));
    chk("safe", 32'h1, 32'(safe));
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    en = 1'b1;
    cfg = '0;
    tmo = 16'd0;
    in_data = 32'ha5c3_1e69;
    led_q = 1'b0;
    do_reset();
    t_reset();
    t_accept();
    t_early();
    t_disabled();
    gap();
    send(32'h0000_3fff);
    t_safe(1'b1);
    t_latched();
    do_reset();
    t_reset();
    t_safe(1'b0);
    report_and_stop();
  end
  // roughly fourteen frame gaps; the run itself uses three
  initial begin
    #(25.0 * 60000);
    errors++;
    report_and_stop();
  end
endmodule
